// file: hdl/radio_config_defines.vh
// constants for the radio configuration word decoder
`ifndef RADIO_CONFIG_DEFINES_VH
`define RADIO_CONFIG_DEFINES_VH
`define CFG_WORD_W 122
`define CFG_CNT_W 8
`define CFG_RESET_WORD 122'h0_20_2000_0000_00e7_0000_0000_e721_0f04
`define LOOP_HI 121
`define LOOP_LO 120
`define PLB_HI 119
`define PLB_LO 112
`define PLA_HI 111
`define PLA_LO 104
`define MWB_HI 103
`define MWB_LO 64
`define MWA_HI 63
`define MWA_LO 24
`define MWL_HI 23
`define MWL_LO 18
`define CHKLEN_BIT 17
`define CHKEN_BIT 16
`define DUAL_BIT 15
`define MODE_BIT 14
`define RATE_BIT 13
`define XTAL_HI 12
`define XTAL_LO 10
`define PWR_HI 9
`define PWR_LO 8
`define CHAN_HI 7
`define CHAN_LO 1
`define DIR_BIT 0
`define PREAMBLE_BITS 9'h008
`define DUAL_CHAN_STEP 8'h08
`define BASE_FREQ_MHZ 12'h960
`define MATCH_MAX_W 6'h28
`endif

// file: hdl/radio_config_word_decoder.v
// configuration word shift register, loader and field decoder
`timescale 1ns/1ps
`include "radio_config_defines.vh"

module radio_config_word_decoder #(
    parameter WORD_W = `CFG_WORD_W
) (
    input wire core_clk,
    input wire resetn,
    input wire configShiftClock,
    input wire configSelect,
    input wire configData,
    output reg [1:0] loopTxClosed,
    output reg txDeviationEnable,
    output reg rxLoopClosed,
    output reg [7:0] payloadLenChB,
    output reg [7:0] payloadLenChA,
    output reg [39:0] rxMatchWordChB,
    output reg [39:0] rxMatchWordChA,
    output reg [39:0] matchMask,
    output reg [5:0] matchWordLength,
    output reg checkLength16,
    output reg checkEnable,
    output reg dualRxEnable,
    output reg packetBurstMode,
    output reg airRate1M,
    output reg rateCrystalOk,
    output reg [4:0] crystalFreqMhz,
    output reg [2:0] crystalFreqSelect,
    output reg signed [5:0] txPowerDbm,
    output reg [6:0] channelNumber,
    output reg [11:0] freqChAMhz,
    output reg [11:0] freqChBMhz,
    output reg [8:0] burstPacketBits,
    output reg receiveMode
);

    // two-flop synchronisers for the three pins
    reg [1:0] sclkSync_q;
    reg [1:0] selSync_q;
    reg [1:0] dataSync_q;
    reg sclkPrev_q;
    reg selPrev_q;
    always @(posedge core_clk) begin
        if (!resetn) begin
            sclkSync_q <= 2'h0;
            selSync_q <= 2'h0;
            dataSync_q <= 2'h0;
            sclkPrev_q <= 1'b0;
            selPrev_q <= 1'b0;
        end else begin
            sclkSync_q <= {sclkSync_q[0], configShiftClock};
            selSync_q <= {selSync_q[0], configSelect};
            dataSync_q <= {dataSync_q[0], configData};
            sclkPrev_q <= sclkSync_q[1];
            selPrev_q <= selSync_q[1];
        end
    end

    wire sclkRise = sclkSync_q[1] & ~sclkPrev_q;
    wire selFall = selPrev_q & ~selSync_q[1];

    // shift register and bit count while strobe is high
    reg [WORD_W-1:0] shift_q;
    reg [`CFG_CNT_W-1:0] count_q;
    reg [WORD_W-1:0] cfg_q;
    reg [WORD_W-1:0] cfg_d;
    reg [WORD_W-1:0] keepMask;
    integer i;

    always @(posedge core_clk) begin
        if (!resetn) begin
            shift_q <= {WORD_W{1'b0}};
            count_q <= {`CFG_CNT_W{1'b0}};
        end else if (selFall) begin
            count_q <= {`CFG_CNT_W{1'b0}};
        end else if (selSync_q[1] && sclkRise) begin
            shift_q <= {shift_q[WORD_W-2:0], dataSync_q[1]}; // msb first
            if (count_q != 8'hff) begin
                count_q <= count_q + 8'h01;
            end
        end
    end

    // mask of low bits actually shifted in
    always @* begin
        keepMask = {WORD_W{1'b0}};
        for (i = 0; i < WORD_W; i = i + 1) begin
            keepMask[i] = (i < count_q);
        end
        cfg_d = (cfg_q & ~keepMask) | (shift_q & keepMask);
    end

    // apply new word on strobe fall
    always @(posedge core_clk) begin
        if (!resetn) begin
            cfg_q <= `CFG_RESET_WORD;
        end else if (selFall) begin
            cfg_q <= cfg_d;
        end
    end

    // crystal code to megahertz
    function [4:0] xtalMhz;
        input [2:0] code;
        begin
            case (code)
                3'h0: xtalMhz = 5'h04;
                3'h1: xtalMhz = 5'h08;
                3'h2: xtalMhz = 5'h0c;
                3'h3: xtalMhz = 5'h10;
                3'h4: xtalMhz = 5'h14;
                default: xtalMhz = 5'h00; // unlisted code
            endcase
        end
    endfunction

    // power code to dBm
    function signed [5:0] pwrDbm;
        input [1:0] code;
        begin
            case (code)
                2'h0: pwrDbm = -6'sd20;
                2'h1: pwrDbm = -6'sd10;
                2'h2: pwrDbm = -6'sd5;
                default: pwrDbm = 6'sd0;
            endcase
        end
    endfunction

    // mask for match word by address width
    function [39:0] widthMask;
        input [5:0] w;
        integer k;
        begin
            widthMask = 40'h0;
            for (k = 0; k < 40; k = k + 1) begin
                widthMask[k] = (k < w);
            end
        end
    endfunction

    // frequency of a channel number plus a fixed step, in megahertz
    function [11:0] chanFreq;
        input [6:0] chan;
        input [7:0] step;
        begin
            chanFreq = `BASE_FREQ_MHZ + {5'h00, chan} + {4'h0, step};
        end
    endfunction

    // check field length in bits, zero when checking is off
    function [8:0] checkBits;
        input isOn;
        input isLong;
        begin
            if (!isOn) begin
                checkBits = 9'h000;
            end else if (isLong) begin
                checkBits = 9'h010;
            end else begin
                checkBits = 9'h008;
            end
        end
    endfunction

    // field slices of the stored word, shared by the output processes
    // the stored word only changes on a strobe fall or in reset
    reg [1:0] loopCode;
    reg [5:0] mwl;
    reg [2:0] xtalCode;
    reg [1:0] pwrCode;
    reg [6:0] chanCode;
    reg [39:0] mwlMask;
    reg [8:0] chkBits;
    always @* begin
        loopCode = cfg_q[`LOOP_HI:`LOOP_LO];
        mwl = cfg_q[`MWL_HI:`MWL_LO];
        xtalCode = cfg_q[`XTAL_HI:`XTAL_LO];
        pwrCode = cfg_q[`PWR_HI:`PWR_LO];
        chanCode = cfg_q[`CHAN_HI:`CHAN_LO];
        mwlMask = widthMask(mwl);
        chkBits = checkBits(cfg_q[`CHKEN_BIT], cfg_q[`CHKLEN_BIT]);
    end

    // loop test state: code bit 1 closes tx, code bit 0 opens rx
    // normal operation wants both code bits low
    always @(posedge core_clk) begin
        if (!resetn) begin
            loopTxClosed <= 2'h0;
            rxLoopClosed <= 1'b1;
            txDeviationEnable <= 1'b1;
        end else begin
            loopTxClosed <= loopCode;
            rxLoopClosed <= ~loopCode[0];
            txDeviationEnable <= ~loopCode[1]; // closed tx loop, no deviation
        end
    end

    // payload lengths per receive channel
    // lengths exclude address and check fields
    always @(posedge core_clk) begin
        if (!resetn) begin
            payloadLenChB <= 8'h00;
            payloadLenChA <= 8'h00;
        end else begin
            payloadLenChB <= cfg_q[`PLB_HI:`PLB_LO];
            payloadLenChA <= cfg_q[`PLA_HI:`PLA_LO];
        end
    end

    // match words cut to the address width
    // bits above the width read as zero so stale bits never match
    always @(posedge core_clk) begin
        if (!resetn) begin
            matchMask <= 40'h0;
            rxMatchWordChB <= 40'h0;
            rxMatchWordChA <= 40'h0;
            matchWordLength <= 6'h00;
        end else begin
            matchMask <= mwlMask;
            rxMatchWordChB <= cfg_q[`MWB_HI:`MWB_LO] & mwlMask;
            rxMatchWordChA <= cfg_q[`MWA_HI:`MWA_LO] & mwlMask;
            matchWordLength <= mwl;
        end
    end

    // check length and enable
    always @(posedge core_clk) begin
        if (!resetn) begin
            checkLength16 <= 1'b0;
            checkEnable <= 1'b0;
        end else begin
            checkLength16 <= cfg_q[`CHKLEN_BIT];
            checkEnable <= cfg_q[`CHKEN_BIT];
        end
    end

    // receive channel count and communication mode
    always @(posedge core_clk) begin
        if (!resetn) begin
            dualRxEnable <= 1'b0;
            packetBurstMode <= 1'b0;
        end else begin
            dualRxEnable <= cfg_q[`DUAL_BIT];
            packetBurstMode <= cfg_q[`MODE_BIT];
        end
    end

    // air rate and its crystal check
    // flag the fast rate on a crystal other than 16 MHz
    always @(posedge core_clk) begin
        if (!resetn) begin
            airRate1M <= 1'b0;
            rateCrystalOk <= 1'b1;
        end else begin
            airRate1M <= cfg_q[`RATE_BIT];
            rateCrystalOk <= ~cfg_q[`RATE_BIT] | (xtalCode == 3'h3);
        end
    end

    // crystal selection
    // codes 5 to 7 are unlisted and decode to zero
    always @(posedge core_clk) begin
        if (!resetn) begin
            crystalFreqSelect <= 3'h0;
            crystalFreqMhz <= 5'h00;
        end else begin
            crystalFreqSelect <= xtalCode;
            crystalFreqMhz <= xtalMhz(xtalCode);
        end
    end

    // transmit power in two's complement dBm
    always @(posedge core_clk) begin
        if (!resetn) begin
            txPowerDbm <= 6'sd0;
        end else begin
            txPowerDbm <= pwrDbm(pwrCode);
        end
    end

    // channel number and receive frequencies
    // channel two sits eight steps above channel one except in reset, where both hold the base
    always @(posedge core_clk) begin
        if (!resetn) begin
            channelNumber <= 7'h00;
            freqChAMhz <= `BASE_FREQ_MHZ;
            freqChBMhz <= `BASE_FREQ_MHZ;
        end else begin
            channelNumber <= chanCode;
            freqChAMhz <= chanFreq(chanCode, 8'h00);
            freqChBMhz <= chanFreq(chanCode, `DUAL_CHAN_STEP);
        end
    end

    // preamble plus address plus payload plus check, channel one
    // preamble is added by the device and not part of any field
    always @(posedge core_clk) begin
        if (!resetn) begin
            burstPacketBits <= 9'h000;
        end else begin
            burstPacketBits <= `PREAMBLE_BITS + {3'h0, mwl}
                + {1'b0, cfg_q[`PLA_HI:`PLA_LO]} + chkBits;
        end
    end

    // active direction
    // zero transmits, one receives
    always @(posedge core_clk) begin
        if (!resetn) begin
            receiveMode <= 1'b0;
        end else begin
            receiveMode <= cfg_q[`DIR_BIT];
        end
    end

endmodule // radio_config_word_decoder

// file: dv/cfg_host.sv
// host model shifting configuration words over the three-wire port
`timescale 1ns/1ps
module cfg_host (
    input logic core_clk,
    output logic configShiftClock,
    output logic configSelect,
    output logic configData
);
    initial begin
        configShiftClock = 1'b0;
        configSelect = 1'b0;
        configData = 1'b0;
    end
    // low n bits msb first at 160 ns, applied at select fall
    task automatic load(input logic [121:0] w, input int n);
        @(posedge core_clk);
        configSelect <= 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            configData <= w[i];
            repeat (8) @(posedge core_clk);
            configShiftClock <= 1'b1;
            repeat (8) @(posedge core_clk);
            configShiftClock <= 1'b0;
        end
        configData <= ~w[0]; // released line holds no stale bit
        repeat (8) @(posedge core_clk);
        configSelect <= 1'b0;
        repeat (10) @(posedge core_clk);
    endtask
endmodule // cfg_host

// file: dv/radio_config_checker_asserts.sv
// checker on the decoded configuration outputs
`timescale 1ns/1ps
module radio_config_checker (
    input wire core_clk,
    input wire resetn,
    input wire configSelect,
    input wire [1:0] loopTxClosed,
    input wire txDeviationEnable,
    input wire rxLoopClosed,
    input wire [7:0] payloadLenChA,
    input wire [39:0] rxMatchWordChA,
    input wire [39:0] matchMask,
    input wire [5:0] matchWordLength,
    input wire checkLength16,
    input wire checkEnable,
    input wire airRate1M,
    input wire rateCrystalOk,
    input wire [4:0] crystalFreqMhz,
    input wire [2:0] crystalFreqSelect,
    input wire [6:0] channelNumber,
    input wire [11:0] freqChAMhz,
    input wire [11:0] freqChBMhz,
    input wire [8:0] burstPacketBits,
    input wire receiveMode
);
    logic settled_q;
    // skip the edge where outputs leave reset values
    always @(posedge core_clk) settled_q <= resetn;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn || !settled_q);
    a_loop_rx_state: assert property (rxLoopClosed == !loopTxClosed[0])
        else $error("rx loop state wrong");
    a_loop_tx_dev: assert property (txDeviationEnable == !loopTxClosed[1])
        else $error("tx deviation wrong");
    a_freq_ch_a: assert property (freqChAMhz == 12'h960 + channelNumber)
        else $error("channel one frequency wrong");
    a_freq_ch_b: assert property (freqChBMhz == freqChAMhz + 12'h008)
        else $error("channel two frequency wrong");
    a_rate_crystal: assert property (rateCrystalOk == !(airRate1M && crystalFreqSelect != 3'h3))
        else $error("rate crystal flag wrong");
    a_crystal_map: assert property (crystalFreqMhz ==
        ((crystalFreqSelect < 3'h5) ? {crystalFreqSelect, 2'h0} + 5'h04 : 5'h00))
        else $error("crystal frequency wrong");
    a_packet_bits: assert property (burstPacketBits == 9'h008 + matchWordLength + payloadLenChA
        + (checkEnable ? (checkLength16 ? 9'h010 : 9'h008) : 9'h000))
        else $error("burst packet size wrong");
    a_mask_width: assert property (matchMask == (40'h1 << matchWordLength) - 40'h1
        && (rxMatchWordChA & ~matchMask) == 40'h0)
        else $error("match mask wrong");
    a_hold_loading: assert property (configSelect [*8] |=>
        $stable(channelNumber) && $stable(receiveMode))
        else $error("outputs moved while shifting");
    cover property (airRate1M && !rateCrystalOk);
    cover property (matchWordLength == 6'h28);
    cover property ($fell(configSelect));
endmodule // radio_config_checker
bind radio_config_word_decoder radio_config_checker u_chk (.*);

// file: dv/test_radio_config_word_decoder.sv
// testbench loading configuration words through the host model
`timescale 1ns/1ps
module test_radio_config_word_decoder;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    int nErrors = 0;
    int totalChecks = 0;
    logic [39:0] m;
    logic [5:0] pwrTab [4] = '{6'h2c, 6'h36, 6'h3b, 6'h00};
    wire configShiftClock, configSelect, configData, txDeviationEnable, rxLoopClosed;
    wire checkLength16, checkEnable, dualRxEnable, packetBurstMode, airRate1M;
    wire rateCrystalOk, receiveMode;
    wire [1:0] loopTxClosed;
    wire [7:0] payloadLenChB, payloadLenChA;
    wire [39:0] rxMatchWordChB, rxMatchWordChA, matchMask;
    wire [5:0] matchWordLength;
    wire [4:0] crystalFreqMhz;
    wire [2:0] crystalFreqSelect;
    wire signed [5:0] txPowerDbm;
    wire [6:0] channelNumber;
    wire [11:0] freqChAMhz, freqChBMhz;
    wire [8:0] burstPacketBits;
    radio_config_word_decoder dut (.*);
    cfg_host host (.*);
    always #5 core_clk = ~core_clk;
    task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
        totalChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #500000;
        nErrors++;
        results();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk("chan", 40'h2, channelNumber);
        chk("width", 40'h8, matchWordLength);
        chk("bits", 40'h38, burstPacketBits);
        // full loads sweeping loop codes, widths and mode flags
        for (int k = 0; k < 4; k++) begin
            m = (40'h1 << (16 + 8 * k)) - 40'h1;
            host.load({2'(k), 8'(16 + k), 8'h40, 40'h12_3456_789a, 40'hab_cdef_0123,
                6'(16 + 8 * k), k[0], k[1], k[0], k[1], k[0], 1'b0, k[1], 1'b1,
                2'(k), 7'h7c, k[0]}, 122);
            chk("loop", 40'(k), loopTxClosed);
            chk("rxLoop", 40'(!k[0]), rxLoopClosed);
            chk("mask", m, matchMask);
            chk("freqA", 40'h9dc, freqChAMhz);
            chk("bits", 40'(88 + 8 * k + (k[1] ? (k[0] ? 16 : 8) : 0)), burstPacketBits);
            chk("dev", 40'(!k[1]), txDeviationEnable);
            chk("plB", 40'(16 + k), payloadLenChB);
            chk("plA", 40'h40, payloadLenChA);
            chk("mwB", 40'h12_3456_789a & m, rxMatchWordChB);
            chk("mwA", 40'hab_cdef_0123 & m, rxMatchWordChA);
            chk("width", 40'(16 + 8 * k), matchWordLength);
            chk("flags", 40'({k[0], k[1], k[0], k[1], k[0]}), 40'({checkLength16,
                checkEnable, dualRxEnable, packetBurstMode, airRate1M}));
            chk("rateOk", 40'(k != 1), rateCrystalOk);
            chk("freqB", 40'h9e4, freqChBMhz);
            chk("dir", 40'(k[0]), receiveMode);
        end
        // partial loads sweep crystal and power codes
        for (int i = 0; i < 5; i++) begin
            host.load(122'({3'(i), 2'(i), 7'(i), 1'b1}), 13);
            chk("xtal", 40'(4 * i + 4), crystalFreqMhz);
            chk("power", 40'(pwrTab[i % 4]), 40'($unsigned(txPowerDbm)));
            chk("keep", 40'h28, matchWordLength);
            chk("xsel", 40'(i), crystalFreqSelect);
            chk("chanP", 40'(i), channelNumber);
        end
        host.load(122'h0, 1);
        chk("dir", 40'h0, receiveMode);
        chk("chan", 40'h4, channelNumber);
        // normal operation load with both loop test bits low
        host.load(122'h0_20_2000_0000_00e7_0000_0000_e721_0f04, 122);
        chk("loop", 40'h0, loopTxClosed);
        chk("bits", 40'h38, burstPacketBits);
        chk("chan", 40'h2, channelNumber);
        results();
    end
endmodule // test_radio_config_word_decoder
